// ===== fllc_lock_detect.sv
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`include "fllc_params.svh"
// Notes on behaviour
// [RULE1] first lock after entering external engaged: output is raw clock over 2R
// [RULE2] after lock, and on unexpected relock attempts, output is raw clock over R
// [RULE3] locked: filter updated every four compares with their average error
// [RULE4] pulses counted per compare cycle, subtracted from factor, signed error; the code takes count minus target instead
// [RULE5] lock after enough samples strictly in lock window; hold in unlock window
// [RULE6] unexpected exit of unlock window sets sticky lock-lost flag
// [RULE7] flag clears by status read then write 1 to flag, or reset
// [RULE8] stop with debug and oscillator-stop off: lock cleared, flag kept
// [RULE9] debug enable dropped during stop: off state, flag set on wake
// [RULE10] factor, select or internal trim change drops lock without flag
// [RULE11] select value 01 means engaged loop on internal reference
// [RULE12] factor field 011 gives multiplication factor 10
// [RULE13] divide field 001 gives division factor two
// [RULE14] range bit 0 selects low range and reference prescale 64
// [RULE15] reset-on-lock-lost at 0 raises interrupt instead of reset
// [RULE16] reset-on-clock-lost 0 interrupts; detect-disable 0 keeps detection on
// [RULE17] after reset the generator runs self-clocked, about 8 MHz out
// [RULE18] status one read-only except the flag-clearing write
// [RULE19] lock bit set on lock, cleared on unlock, change or off
module fllc_lock_detect #(
  parameter int LOCK_WIN = 2,
  parameter int UNLOCK_WIN = 8,
  parameter int LOCK_SAMPLES = 4
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_NRST,
  // register bus
  input wire fllc_pkg::fllc_ahb_req_t I_AHB,
  output fllc_pkg::fllc_ahb_rsp_t O_AHB,
  // oscillator and system
  input wire logic I_DCO_PULSE,
  input wire logic I_CMP_TICK,
  input wire logic I_TRIM_CHG,
  input wire logic I_REF_LOST,
  input wire logic I_STOP,
  input wire logic I_BDM_EN,
  // loop state and requests
  output fllc_pkg::fllc_loop_t O_LOOP,
  output logic O_IRQ,
  output logic O_RST_REQ
);
  import fllc_pkg::*;

  if (LOCK_WIN < 1 || UNLOCK_WIN <= LOCK_WIN || UNLOCK_WIN > 16000 ||
      LOCK_SAMPLES < 1 || LOCK_SAMPLES > 15) begin : g_chk
    $error("fllc_lock_detect: window or sample count out of range");
  end

  localparam logic signed [15:0] LWIN = 16'(LOCK_WIN);
  localparam logic signed [15:0] UWIN = 16'(UNLOCK_WIN);
  localparam logic [3:0] SMP_LAST = 4'(LOCK_SAMPLES - 1);
  localparam fllc_regs_t RST_VAL = '{
    hready: 1'b1,
    st: ST_SCM,
    div: `FLLC_RST_DIV,
    ctrl1: `FLLC_RST_CTRL1,
    ctrl2: `FLLC_RST_CTRL2,
    mask: `FLLC_RST_MASK,
    default: '0
  };

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic engaged(input logic [1:0] c);
    return c == CLOCK_SELECT_FIELD_FEI || c == CLOCK_SELECT_FIELD_FEE; // RULE11
  endfunction

  function automatic logic [8:0] rdiv(input logic [2:0] f);
    return 9'h001 << f; // RULE13
  endfunction

  function automatic logic [15:0] mfd_n(input logic [2:0] m);
    return 16'(4 + 2 * int'(m)); // RULE12
  endfunction

  fllc_regs_t r, n;
  logic [1:0] clock_select_field;
  logic [15:0] target;
  logic [15:0] cnt_now;
  logic signed [15:0] err_now;
  logic in_lock;
  logic in_unlk;
  logic acc_ok;
  logic rd_evt;
  logic wr_c1;
  logic wr_c2;
  logic wr_s1;
  logic [7:0] wdat;
  logic exp_chg;
  logic lol_set;
  logic loc_set;
  logic [2:0] ev;
  logic signed [17:0] sum;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    clock_select_field = r.ctrl1[`FLLC_C1_CLOCK_SELECT_FIELD_LSB +: 2];
    // low range counts a prescaled reference window
    target = r.ctrl1[`FLLC_C1_RANGE] ?
      mfd_n(r.ctrl2[`FLLC_C2_MFD_LSB +: 3]) :
      16'(mfd_n(r.ctrl2[`FLLC_C2_MFD_LSB +: 3]) * `FLLC_PRESCALE_LO); // RULE14
    cnt_now = r.pcnt + 16'(I_DCO_PULSE);
    err_now = signed'(cnt_now - target); // RULE4
    in_lock = err_now > -LWIN && err_now < LWIN;
    in_unlk = err_now > -UWIN && err_now < UWIN;
    sum = signed'(r.acc) + 18'(err_now);
    acc_ok = I_AHB.hsel && I_AHB.htrans[1] && I_AHB.hready;
    rd_evt = acc_ok && !I_AHB.hwrite && I_AHB.haddr[7:0] == `FLLC_OFF_EVT;
    wdat = I_AHB.hwdata[7:0];
    wr_c1 = r.wr_pend && r.wr_addr == `FLLC_OFF_CTRL1;
    wr_c2 = r.wr_pend && r.wr_addr == `FLLC_OFF_CTRL2;
    wr_s1 = r.wr_pend && r.wr_addr == `FLLC_OFF_STAT1;
    exp_chg = (wr_c1 && wdat[`FLLC_C1_CLOCK_SELECT_FIELD_LSB +: 2] != clock_select_field) ||
      (wr_c2 && wdat[`FLLC_C2_MFD_LSB +: 3] !=
        r.ctrl2[`FLLC_C2_MFD_LSB +: 3]) ||
      (I_TRIM_CHG && clock_select_field == CLOCK_SELECT_FIELD_FEI); // RULE10
    lol_set = 1'b0;
    loc_set = I_REF_LOST && !r.ctrl1[`FLLC_C1_CLOCK_LOSS_DETECT_DISABLE]; // RULE16
    ev = '0;
    n = r;
    n.filt_vld = 1'b0;
    n.rst_req = 1'b0;
    n.in_stop = I_STOP;
    n.bdm_q = I_BDM_EN;

    // register writes land in the data phase
    if (wr_c1) begin
      n.ctrl1 = wdat & 8'hfe;
    end
    if (wr_c2) begin
      n.ctrl2 = wdat;
    end
    if (r.wr_pend && r.wr_addr == `FLLC_OFF_MASK) begin
      n.mask = wdat[2:0];
    end
    n.wr_pend = acc_ok && I_AHB.hwrite;
    n.wr_addr = I_AHB.haddr[7:0];

    n.pcnt = I_CMP_TICK ? 16'h0000 : cnt_now; // RULE4
    if (I_CMP_TICK) begin
      n.err = err_now;
    end

    case (r.st)
      ST_SCM: begin
        if (engaged(clock_select_field)) begin
          n.st = ST_UNLK;
          n.first_done = 1'b0;
          n.smp = '0;
        end
      end
      ST_UNLK: begin
        if (!engaged(clock_select_field)) begin
          n.st = ST_SCM;
        end else if (I_CMP_TICK) begin
          n.filt = err_now;
          n.filt_vld = 1'b1;
          if (!in_lock) begin
            n.smp = '0;
          end else if (r.smp == SMP_LAST) begin // RULE5
            n.st = ST_LOCK;
            n.lock = 1'b1; // RULE19
            n.first_done = 1'b1;
            n.acc = '0;
            n.avg_n = '0;
            ev[`FLLC_EV_LOCKED] = 1'b1;
          end else begin
            n.smp = r.smp + 4'h1;
          end
        end
      end
      ST_LOCK: begin
        if (!engaged(clock_select_field)) begin
          n.st = ST_SCM;
          n.lock = 1'b0;
        end else if (I_CMP_TICK) begin
          // averaging trades tracking speed for jitter immunity
          n.acc = 18'(sum);
          n.avg_n = r.avg_n + 2'h1;
          if (r.avg_n == `FLLC_AVG_CMPS) begin // RULE3
            n.filt = 16'(sum >>> `FLLC_AVG_SHIFT);
            n.filt_vld = 1'b1;
            n.acc = '0;
          end
          if (!in_unlk && !exp_chg) begin // RULE5
            n.st = ST_UNLK;
            n.lock = 1'b0;
            n.smp = '0;
            lol_set = 1'b1; // RULE6
          end
        end
      end
      ST_OFF: begin
        if (!I_STOP) begin
          n.st = engaged(clock_select_field) ? ST_UNLK : ST_SCM;
          n.smp = '0;
          n.stop_unexp = 1'b0;
          lol_set = r.stop_unexp; // RULE9
        end
      end
      default: begin
        n.st = ST_SCM;
      end
    endcase

    // expected loss of lock: no sticky flag
    if (exp_chg && (r.st == ST_UNLK || r.st == ST_LOCK)) begin // RULE10
      n.st = engaged(n.ctrl1[`FLLC_C1_CLOCK_SELECT_FIELD_LSB +: 2]) ? ST_UNLK : ST_SCM;
      n.lock = 1'b0; // RULE19
      n.smp = '0;
    end
    if (I_STOP && !r.in_stop && !I_BDM_EN &&
        !r.ctrl1[`FLLC_C1_OSCILLATOR_STOP_ENABLE]) begin // RULE8
      n.st = ST_OFF;
      n.lock = 1'b0; // RULE19
    end else if (r.in_stop && I_STOP && r.bdm_q && !I_BDM_EN &&
        r.st != ST_OFF) begin // RULE9
      n.st = ST_OFF;
      n.lock = 1'b0;
      n.stop_unexp = 1'b1;
    end

    // clear first so that a same-cycle event still sets
    if (acc_ok && !I_AHB.hwrite && I_AHB.haddr[7:0] == `FLLC_OFF_STAT1) begin
      n.rd_armed = 1'b1;
    end
    if (wr_s1 && wdat[`FLLC_S1_IF] && r.rd_armed) begin // RULE7
      n.iflag = 1'b0;
      n.sticky_lock_lost_flag = 1'b0;
      n.locs = 1'b0;
      n.rd_armed = 1'b0;
    end
    if (lol_set) begin
      n.sticky_lock_lost_flag = 1'b1; // RULE6
      ev[`FLLC_EV_LOL] = 1'b1;
      if (r.ctrl2[`FLLC_C2_RESET_ON_LOCK_LOST]) begin
        n.rst_req = 1'b1;
      end else begin
        n.iflag = 1'b1; // RULE15
      end
    end
    if (loc_set) begin
      n.locs = 1'b1;
      ev[`FLLC_EV_LOC] = 1'b1;
      if (r.ctrl2[`FLLC_C2_RESET_ON_CLOCK_LOST]) begin
        n.rst_req = 1'b1;
      end else begin
        n.iflag = 1'b1; // RULE16
      end
    end
    n.evt = (rd_evt ? 3'h0 : r.evt) | ev;
    n.irq = |(n.evt & n.mask);

    n.div = rdiv(n.ctrl2[`FLLC_C2_RFD_LSB +: 3]); // RULE2
    if (n.st == ST_UNLK && !n.first_done) begin
      n.div = {n.div[7:0], 1'b0}; // RULE1
    end

    // read data registered in the address phase
    n.rdata = '0;
    if (acc_ok && !I_AHB.hwrite) begin
      case (I_AHB.haddr[7:0])
        `FLLC_OFF_CTRL1: n.rdata = {24'h000000, r.ctrl1};
        `FLLC_OFF_CTRL2: n.rdata = {24'h000000, r.ctrl2};
        `FLLC_OFF_STAT1: n.rdata = {28'h0000000, r.locs, r.sticky_lock_lost_flag, r.lock,
          r.iflag}; // RULE18
        `FLLC_OFF_STAT2: n.rdata = {16'h0000, r.err};
        `FLLC_OFF_EVT: n.rdata = {29'h0, r.evt};
        `FLLC_OFF_MASK: n.rdata = {29'h0, r.mask};
        default: n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_NRST) begin
      r <= RST_VAL; // RULE17
    end else begin
      r <= n;
    end
  end

  assign O_AHB = '{hreadyout: r.hready, hresp: 1'b0, hrdata: r.rdata};
  assign O_LOOP = '{state: r.st, lock: r.lock, div: r.div, filt: r.filt,
    filt_vld: r.filt_vld};
  assign O_IRQ = r.irq;
  assign O_RST_REQ = r.rst_req;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_NRST);

  property p_first_div;
    r.st == ST_UNLK && !r.first_done |->
      r.div == {rdiv(r.ctrl2[`FLLC_C2_RFD_LSB +: 3]) << 1};
  endproperty
  a_first_div: assert property (p_first_div) // RULE1
    else $error("first lock divider is not 2R");

  property p_lock_div;
    r.st == ST_LOCK |-> r.div == rdiv(r.ctrl2[`FLLC_C2_RFD_LSB +: 3]);
  endproperty
  a_lock_div: assert property (p_lock_div) // RULE2
    else $error("locked divider is not R");

  property p_avg;
    r.st == ST_LOCK && n.st == ST_LOCK && I_CMP_TICK &&
      r.avg_n == `FLLC_AVG_CMPS |=> r.filt_vld && r.filt == $past(
        16'(sum >>> `FLLC_AVG_SHIFT));
  endproperty
  a_avg: assert property (p_avg) // RULE3
    else $error("filter average not issued after four compares");

  property p_err;
    I_CMP_TICK |=> r.err == $past(err_now) && r.pcnt == 16'h0000;
  endproperty
  a_err: assert property (p_err) // RULE4
    else $error("count error not captured at compare end");

  property p_lock_entry;
    $rose(r.lock) |-> $past(in_lock) && $past(r.smp) == SMP_LAST;
  endproperty
  a_lock_entry: assert property (p_lock_entry) // RULE5
    else $error("lock declared without window samples");

  property p_sticky_lock_lost_flag;
    r.st == ST_LOCK && n.st == ST_UNLK && !exp_chg |=> r.sticky_lock_lost_flag ##1 r.sticky_lock_lost_flag;
  endproperty
  a_sticky_lock_lost_flag: assert property (p_sticky_lock_lost_flag) // RULE6
    else $error("sticky lock-lost flag not held");

  property p_clear;
    wr_s1 && wdat[`FLLC_S1_IF] && r.rd_armed && !lol_set && !loc_set
      |=> !r.sticky_lock_lost_flag && !r.iflag;
  endproperty
  a_clear: assert property (p_clear) // RULE7
    else $error("flag clear sequence ignored");

  property p_stop_keep;
    r.st != ST_OFF ##1 r.st == ST_OFF && !r.stop_unexp |->
      !r.lock && r.sticky_lock_lost_flag == $past(r.sticky_lock_lost_flag);
  endproperty
  a_stop_keep: assert property (p_stop_keep) // RULE8
    else $error("expected stop changed sticky flag");

  property p_expected;
    exp_chg && r.st == ST_LOCK |=> !r.lock && r.sticky_lock_lost_flag == $past(r.sticky_lock_lost_flag);
  endproperty
  a_expected: assert property (p_expected) // RULE10
    else $error("expected change mishandled");

  property p_lol_irq;
    lol_set && !r.ctrl2[`FLLC_C2_RESET_ON_LOCK_LOST] |=> r.iflag && !r.rst_req;
  endproperty
  a_lol_irq: assert property (p_lol_irq) // RULE15
    else $error("lock loss did not request interrupt");

  property p_scm;
    $rose(I_NRST) |-> r.st == ST_SCM && !r.lock;
  endproperty
  a_scm: assert property (p_scm) // RULE17
    else $error("not self-clocked after reset");

  c_lock: cover property (r.st == ST_UNLK ##1 r.st == ST_LOCK);
  c_lost: cover property (r.st == ST_LOCK ##1 r.st == ST_UNLK && r.sticky_lock_lost_flag);
  c_avg: cover property (r.st == ST_LOCK && r.filt_vld);
  c_off: cover property (r.st == ST_OFF ##[1:50] r.st == ST_UNLK);

endmodule // fllc_lock_detect

// ===== fllc_osc_model.sv
module fllc_osc_model (
  // clock
  input wire logic clk,
  // oscillator side
  output logic o_pulse,
  output logic o_tick,
  output logic o_ref_lost
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_pulse = 1'b0;
    o_tick = 1'b0;
    o_ref_lost = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one compare cycle: cnt pulses, tick rides on the last one
  // slow puts an idle cycle before each pulse, as a sluggish oscillator
  task automatic cmp(input int cnt, input bit slow);
    for (int i = 1; i <= cnt; i++) begin
      if (slow) begin
        o_pulse <= 1'b0;
        o_tick <= 1'b0;
        @(posedge clk);
      end
      o_pulse <= 1'b1;
      o_tick <= (i == cnt);
      @(posedge clk);
    end
  endtask

  // pins driven low after a run, so a following compare starts from idle
  task automatic rest();
    o_pulse <= 1'b0;
    o_tick <= 1'b0;
  endtask

  task automatic lose_ref();
    o_ref_lost <= 1'b1;
    @(posedge clk);
    o_ref_lost <= 1'b0;
  endtask
endmodule // fllc_osc_model

// ===== fllc_params.svh
`ifndef FLLC_PARAMS_SVH
`define FLLC_PARAMS_SVH
// register byte offsets
`define FLLC_OFF_CTRL1 8'h00
`define FLLC_OFF_CTRL2 8'h04
`define FLLC_OFF_STAT1 8'h08
`define FLLC_OFF_STAT2 8'h0c
`define FLLC_OFF_EVT 8'h10
`define FLLC_OFF_MASK 8'h14
// control one fields
`define FLLC_C1_HGO 7
`define FLLC_C1_RANGE 6
`define FLLC_C1_REFERENCE_SELECT 5
`define FLLC_C1_CLOCK_SELECT_FIELD_LSB 3
`define FLLC_C1_OSCILLATOR_STOP_ENABLE 2
`define FLLC_C1_CLOCK_LOSS_DETECT_DISABLE 1
// control two fields
`define FLLC_C2_RESET_ON_LOCK_LOST 7
`define FLLC_C2_MFD_LSB 4
`define FLLC_C2_RESET_ON_CLOCK_LOST 3
`define FLLC_C2_RFD_LSB 0
// status one fields
`define FLLC_S1_IF 0
`define FLLC_S1_LOCK 1
`define FLLC_S1_STICKY_LOCK_LOST_FLAG 2
`define FLLC_S1_LOCS 3
// event status and mask fields
`define FLLC_EV_LOL 0
`define FLLC_EV_LOC 1
`define FLLC_EV_LOCKED 2
// reset values
`define FLLC_RST_CTRL1 8'h00
`define FLLC_RST_CTRL2 8'h00
`define FLLC_RST_MASK 3'h0
`define FLLC_RST_DIV 9'h001
// loop constants
`define FLLC_PRESCALE_LO 16'h0040
`define FLLC_AVG_CMPS 2'h3
`define FLLC_AVG_SHIFT 2
`define FLLC_SCM_OUT_KHZ 8000
`define FLLC_SCM_BUS_KHZ 4000
`endif

// ===== fllc_pkg.sv
package fllc_pkg;
  typedef enum logic [1:0] {
    ST_SCM = 2'h0,
    ST_UNLK = 2'h1,
    ST_LOCK = 2'h3,
    ST_OFF = 2'h2
  } fllc_state_t;

  typedef enum logic [1:0] {
    CLOCK_SELECT_FIELD_SCM = 2'h0,
    CLOCK_SELECT_FIELD_FEI = 2'h1,
    CLOCK_SELECT_FIELD_FEE = 2'h2,
    CLOCK_SELECT_FIELD_FBE = 2'h3
  } fllc_clock_select_field_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } fllc_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } fllc_ahb_rsp_t;

  typedef struct packed {
    fllc_state_t state;
    logic lock;
    logic [8:0] div;
    logic [15:0] filt;
    logic filt_vld;
  } fllc_loop_t;

  typedef struct packed {
    fllc_state_t st;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic iflag;
    logic sticky_lock_lost_flag;
    logic locs;
    logic lock;
    logic first_done;
    logic [3:0] smp;
    logic [15:0] pcnt;
    logic [15:0] err;
    logic [17:0] acc;
    logic [1:0] avg_n;
    logic [15:0] filt;
    logic filt_vld;
    logic [2:0] evt;
    logic [2:0] mask;
    logic irq;
    logic rst_req;
    logic [8:0] div;
    logic rd_armed;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic hready;
    logic in_stop;
    logic bdm_q;
    logic stop_unexp;
  } fllc_regs_t;
endpackage : fllc_pkg

// ===== test_fllc_lock_detect.sv
module test_fllc_lock_detect;
  timeunit 1ns;
  timeprecision 1ns;
  import fllc_pkg::*;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic stop = 1'b0;
  logic bdm = 1'b0;
  logic trim = 1'b0;
  logic irq, rst_req, pulse, tick, ref_lost;
  logic [15:0] lfilt;
  fllc_ahb_req_t req;
  fllc_ahb_rsp_t rsp;
  fllc_loop_t loop;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nvld = 0;
  int nrq = 0;
  int n0 = 0;
  int t = 0;

  assign req = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};

  always #5 clk = ~clk;

  fllc_lock_detect fllc_lock_detect_i (
    .I_MCLK(clk), .I_NRST(nrst), .I_AHB(req), .O_AHB(rsp),
    .I_DCO_PULSE(pulse), .I_CMP_TICK(tick), .I_TRIM_CHG(trim),
    .I_REF_LOST(ref_lost), .I_STOP(stop), .I_BDM_EN(bdm),
    .O_LOOP(loop), .O_IRQ(irq), .O_RST_REQ(rst_req));

  fllc_osc_model fllc_osc_model_i (
    .clk(clk), .o_pulse(pulse), .o_tick(tick), .o_ref_lost(ref_lost));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // pulse outputs are caught at the edge, before they drop again
  always @(posedge clk) begin
    cyc++;
    if (loop.filt_vld === 1'b1) begin
      nvld++;
      lfilt = loop.filt;
    end
    if (rst_req === 1'b1) nrq++;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // no fixed latency assumed: each phase waits for hready
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    r = rsp.hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic cmps(input int n, input int c, input bit s);
    repeat (n) fllc_osc_model_i.cmp(c, s);
    fllc_osc_model_i.rest();
    w(3);
  endtask

  task automatic done();
    t++;
    $display("test %0d done", t);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    w(1);
    // reset state, register defaults, unmapped and read-only places
    chk(loop.state, ST_SCM);
    chk(loop.div, 9'h1);
    rdc(8'h00, 32'h0, 32'hffffffff);
    rdc(8'h04, 32'h0, 32'hffffffff);
    rdc(8'h20, 32'h0, 32'hffffffff);
    chk(rsp.hresp, 32'h0);
    wr(8'h08, 32'hff);
    rdc(8'h08, 32'h0, 32'hffffffff);
    done();
    // external engaged, factor 10, divide 2: first unlock at 2R
    wr(8'h14, 32'h7);
    wr(8'h04, 32'h31);
    wr(8'h00, 32'h51);
    rdc(8'h00, 32'h50, 32'hffffffff);
    w(2);
    chk(loop.state, ST_UNLK);
    chk(loop.div, 9'h4);
    done();
    // an outlier inside the run must hold off lock
    cmps(3, 10, 1'b1);
    cmps(1, 12, 1'b0);
    chk(loop.state, ST_UNLK);
    cmps(4, 10, 1'b0);
    chk(loop.state, ST_LOCK);
    chk(loop.div, 9'h2);
    chk(irq, 1'h1);
    rdc(8'h08, 32'h2, 32'hf);
    rdc(8'h10, 32'h4, 32'h7);
    w(2);
    chk(irq, 1'h0);
    done();
    // locked filter: one update per four compares, averaged
    n0 = nvld;
    cmps(1, 14, 1'b0);
    rdc(8'h0c, 32'h4, 32'hffff);
    cmps(1, 14, 1'b0);
    cmps(1, 10, 1'b0);
    chk(nvld, n0);
    cmps(1, 10, 1'b0);
    chk(nvld, n0 + 1);
    chk(lfilt, 16'h2);
    done();
    // unexpected loss: sticky flag, interrupt, divisor stays R
    cmps(1, 20, 1'b0);
    chk(loop.state, ST_UNLK);
    chk(loop.div, 9'h2);
    chk(irq, 1'h1);
    rdc(8'h10, 32'h1, 32'h7);
    rdc(8'h08, 32'h5, 32'hf);
    wr(8'h08, 32'h1);
    rdc(8'h08, 32'h0, 32'hf);
    done();
    // expected loss by factor change, then reset request on loss
    cmps(4, 10, 1'b0);
    wr(8'h04, 32'h41);
    w(2);
    chk(loop.lock, 1'h0);
    rdc(8'h08, 32'h0, 32'hf);
    wr(8'h04, 32'hc1);
    cmps(4, 12, 1'b0);
    chk(loop.lock, 1'h1);
    n0 = nrq;
    cmps(1, 30, 1'b0);
    chk(nrq, n0 + 1);
    wr(8'h04, 32'h41);
    fllc_osc_model_i.lose_ref();
    w(3);
    rdc(8'h08, 32'h8, 32'h8);
    done();
    // stop entry keeps the flag; debug drop in stop sets it on wake
    cmps(4, 12, 1'b0);
    stop <= 1'b1;
    w(3);
    chk(loop.state, ST_OFF);
    chk(loop.lock, 1'h0);
    rdc(8'h08, 32'h4, 32'h4);
    wr(8'h08, 32'h1);
    stop <= 1'b0;
    bdm <= 1'b1;
    w(3);
    stop <= 1'b1;
    w(2);
    bdm <= 1'b0;
    w(2);
    chk(loop.state, ST_OFF);
    stop <= 1'b0;
    w(3);
    rdc(8'h08, 32'h4, 32'h4);
    wr(8'h08, 32'h1);
    done();
    // internal engaged: trim drops lock without the flag
    wr(8'h00, 32'h48);
    w(2);
    chk(loop.state, ST_UNLK);
    cmps(4, 12, 1'b0);
    chk(loop.lock, 1'h1);
    trim <= 1'b1;
    w(1);
    trim <= 1'b0;
    w(3);
    chk(loop.lock, 1'h0);
    rdc(8'h08, 32'h0, 32'h4);
    // low range: target is factor times 64
    wr(8'h00, 32'h08);
    w(2);
    cmps(4, 768, 1'b0);
    chk(loop.lock, 1'h1);
    done();
    // detection disabled, then clock loss asks for a reset
    wr(8'h00, 32'h0a);
    fllc_osc_model_i.lose_ref();
    w(3);
    rdc(8'h08, 32'h0, 32'h8);
    wr(8'h00, 32'h08);
    wr(8'h04, 32'h49);
    n0 = nrq;
    fllc_osc_model_i.lose_ref();
    w(3);
    chk(nrq, n0 + 1);
    rdc(8'h08, 32'h8, 32'h9);
    // mid-run reset wipes the sticky flags
    nrst <= 1'b0;
    w(2);
    nrst <= 1'b1;
    w(1);
    rdc(8'h08, 32'h0, 32'hf);
    chk(loop.state, ST_SCM);
    done();
    finish_test();
  end
endmodule // test_fllc_lock_detect
